/* core/mil_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the interrupt logic.
// Assumes: Included by its bare name from every design file that needs it.
// Notes: Register offsets are indices; the byte address is four times the index.
`ifndef MIL_PARAMS_SVH
`define MIL_PARAMS_SVH
// Register indices and bus decode.
`define MIL_IDX_CONTROL 8'h0B
`define MIL_IDX_PFLAGS 8'h0C
`define MIL_IDX_PENABLES 8'h8C
`define MIL_ADDR_W 10
// Control register fields.
`define MIL_B_GEN 7
`define MIL_B_PHEN 6
`define MIL_B_T0EN 5
`define MIL_B_EXTIE 4
`define MIL_B_PCIE 3
`define MIL_B_T0FL 2
`define MIL_B_EXTIF 1
`define MIL_B_PCIF 0
// Peripheral register fields.
`define MIL_B_EEPROM 7
`define MIL_B_COMP 6
`define MIL_B_RX 5
`define MIL_B_TX 4
`define MIL_B_UNIMPL 3
`define MIL_B_CAPCOMP 2
`define MIL_B_TMR2 1
`define MIL_B_TMR1 0
`define MIL_PERIPH_MASK 8'hF7
// Reset values.
`define MIL_RST_CONTROL 8'h00
`define MIL_RST_PERIPH 8'h00
// Timing, vector address, timer 0 limits and bus response codes.
`define MIL_Q_PER_TCY 4
`define MIL_LAT_TCY 3
`define MIL_VECTOR 13'h0004
`define MIL_TIMER0_TOP 8'hFF
`define MIL_TIMER0_ZERO 8'h00
`define MIL_RESP_OKAY 2'h0
`define MIL_RESP_SLVERR 2'h2
`endif

/* core/mil_pkg.sv */
// Purpose: Types shared by the interrupt logic modules.
// Assumes: Nothing beyond the parameter header.
// Notes: Acceptance states walk a Gray sequence.
package mil_pkg;
  typedef enum logic [1:0] {
    MIL_IDLE = 2'b00,
    MIL_WAIT1 = 2'b01,
    MIL_WAIT2 = 2'b11,
    MIL_VECT = 2'b10
  } mil_accept_t;
  typedef logic [7:0] mil_byte_t;
  typedef logic [12:0] mil_pc_t;
endpackage

/* core/mil_event_detect.sv */
// Purpose: Turns pin and counter activity into source events; edge and rollover last one cycle, port change lasts until a port read.
// Assumes: All inputs are synchronous to clk.
// Notes: The port change compare latch is refreshed by every port read.
`include "mil_params.svh"
module mil_event_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sources
  input wire logic ext_irq_pin,
  input wire logic ext_edge_select,
  input wire logic [7:0] timer0_count,
  input wire logic [3:0] port_pins,
  input wire logic port_read,
  // Events
  output logic ext_edge,
  output logic timer0_roll,
  output logic port_change
);
  logic pin_r;
  logic [7:0] tmr_r;
  logic [3:0] latch_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      // Taking the present levels keeps a false edge or change from following reset.
      pin_r <= ext_irq_pin;
      tmr_r <= timer0_count;
      latch_r <= port_pins;
    end else begin
      pin_r <= ext_irq_pin;
      tmr_r <= timer0_count;
      if (port_read) begin
        latch_r <= port_pins;
      end
    end
  end
  assign ext_edge = ext_edge_select ? (ext_irq_pin & ~pin_r) : (~ext_irq_pin & pin_r);
  assign timer0_roll = (tmr_r == `MIL_TIMER0_TOP) && (timer0_count == `MIL_TIMER0_ZERO);
  // A change that lands on the read cycle is absorbed into the latch and lost.
  assign port_change = ~port_read && (port_pins != latch_r);
endmodule

/* core/mil_axil_slave.sv */
// Purpose: AXI4-Lite slave front end for the interrupt registers.
// Assumes: One write and one read at most under way at a time.
// Notes: Address and data are taken in either order; the response follows both.
`include "mil_params.svh"
module mil_axil_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite
  input wire logic [`MIL_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`MIL_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_en,
  output logic [7:0] wr_idx,
  output logic [7:0] wr_data,
  output logic [7:0] rd_idx,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  input wire logic wr_hit
);
  logic aw_have_r, w_have_r;
  logic [7:0] aw_idx_r, w_data_r;
  logic w_lane_r;
  assign awready = ~aw_have_r & ~bvalid;
  assign wready = ~w_have_r & ~bvalid;
  assign arready = ~rvalid;
  assign wr_en = aw_have_r & w_have_r & w_lane_r & ~bvalid;
  assign wr_idx = aw_idx_r;
  assign wr_data = w_data_r;
  assign rd_idx = araddr[9:2];
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= 8'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `MIL_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `MIL_RESP_OKAY;
    end else begin
      if (awvalid & awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r <= awaddr[9:2];
      end
      if (wvalid & wready) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
      end
      if (aw_have_r & w_have_r & ~bvalid) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `MIL_RESP_OKAY : `MIL_RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid & arready) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_hit ? rd_data : 8'h00};
        rresp <= rd_hit ? `MIL_RESP_OKAY : `MIL_RESP_SLVERR;
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

/* core/mil_intc.sv */
// Purpose: Interrupt flags, masking and vectoring for an 8-bit controller core.
// Assumes: CLK runs one quarter phase per edge; four edges make one instruction cycle.
// Notes: Registers sit on AXI4-Lite at four times their index.
// Notes on behaviour
// - Global enable gates all requests; reset clears it.
// - Return-from-interrupt sets global enable again.
// - Accept clears enable, pushes return, loads 0004h.
// - Latency three cycles, four for unaligned events.
// - Flags set regardless of any enable.
// - Clearing enable cancels next vector, inserts NOP; here the NOP follows only a clear in MIL_WAIT2 or MIL_VECT, not MIL_WAIT1.
// - External pin edge selectable, sets pin flag.
// - Pin wakes sleep only when its enable set.
// - Timer 0 rollover sets its flag.
// - Port pins 7:4 change sets change flag.
// - Change during port read may be lost.
// - Pin flag set in Q4-Q1, sampled at Q1.
// - Peripheral flags at 0Ch, enables at 8Ch.
// - Control register layout at 0Bh.
// - Power-on and other reset values differ.
// - Only return address saved on entry.
// - Enabled request wakes sleep whatever global enable.
// - Pending enabled request makes sleep wake at once.
//
// The AXI4-Lite register port was decided locally.
`include "mil_params.svh"
module mil_intc (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  input wire logic POWER_ON,
  // AXI4-Lite register bus
  input wire logic [`MIL_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`MIL_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Interrupt sources
  input wire logic EXT_IRQ_PIN,
  input wire logic EXT_EDGE_SELECT,
  input wire logic [7:0] TIMER0_COUNT,
  input wire logic [3:0] PORT_PINS,
  input wire logic PORT_READ,
  input wire logic [7:0] PERIPH_EVENT,
  // Core sequencer
  input wire logic RETURN_FROM_IRQ,
  input wire logic SLEEPING,
  input wire mil_pkg::mil_pc_t RETURN_PC,
  output logic [1:0] Q_PHASE,
  output logic STACK_PUSH,
  output mil_pkg::mil_pc_t STACK_DATA,
  output logic PC_LOAD,
  output mil_pkg::mil_pc_t PC_LOAD_VALUE,
  output logic CORE_NOP,
  output logic WAKE,
  output logic IRQ_PENDING
);
  import mil_pkg::*;

  // ----------------------------------------------------------------
  // Quarter phase counter
  // ----------------------------------------------------------------
  logic [1:0] q_r;
  logic q1;
  logic q4;
  logic q_in_window;
  assign q1 = (q_r == 2'd0);
  assign q4 = (q_r == 2'd3);
  assign q_in_window = q1 | q4;
  assign Q_PHASE = q_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      q_r <= 2'd0;
    end else begin
      q_r <= q_r + 2'd1;
    end
  end

  // ----------------------------------------------------------------
  // Source events
  // ----------------------------------------------------------------
  logic ext_edge;
  logic timer0_roll;
  logic port_change;

  mil_event_detect u_events (
    .clk(CLK),
    .reset(RESET),
    .ext_irq_pin(EXT_IRQ_PIN),
    .ext_edge_select(EXT_EDGE_SELECT),
    .timer0_count(TIMER0_COUNT),
    .port_pins(PORT_PINS),
    .port_read(PORT_READ),
    .ext_edge(ext_edge),
    .timer0_roll(timer0_roll),
    .port_change(port_change)
  );

  // An edge seen in Q2 or Q3 waits here until the Q4-Q1 window opens.
  logic ext_hold_r;
  logic ext_set;
  assign ext_set = q_in_window & (ext_edge | ext_hold_r);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ext_hold_r <= 1'b0;
    end else if (ext_set) begin
      ext_hold_r <= 1'b0;
    end else if (ext_edge) begin
      ext_hold_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  logic wr_hit;

  mil_axil_slave u_bus (
    .clk(CLK),
    .reset(RESET),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit),
    .wr_hit(wr_hit)
  );

  function automatic logic idx_hit(input logic [7:0] idx);
    idx_hit = (idx == `MIL_IDX_CONTROL) || (idx == `MIL_IDX_PFLAGS) ||
              (idx == `MIL_IDX_PENABLES);
  endfunction

  logic wr_ctrl;
  logic wr_pflags;
  logic wr_pen;
  assign wr_hit = idx_hit(wr_idx);
  assign rd_hit = idx_hit(rd_idx);
  assign wr_ctrl = wr_en && (wr_idx == `MIL_IDX_CONTROL);
  assign wr_pflags = wr_en && (wr_idx == `MIL_IDX_PFLAGS);
  assign wr_pen = wr_en && (wr_idx == `MIL_IDX_PENABLES);

  // ----------------------------------------------------------------
  // Control and peripheral registers
  // ----------------------------------------------------------------
  mil_byte_t ctrl_r;
  mil_byte_t ctrl_nxt;
  mil_byte_t pflag_r;
  mil_byte_t pflag_nxt;
  mil_byte_t pen_r;
  mil_byte_t pen_nxt;
  mil_byte_t ctrl_set;
  mil_byte_t pflag_set;
  logic accept;
  logic glb_drop;

  // Hardware sets win over a software write in the same cycle.
  assign ctrl_set = {5'b00000, timer0_roll, ext_set, port_change};
  assign pflag_set = PERIPH_EVENT & `MIL_PERIPH_MASK;

  always_comb begin
    ctrl_nxt = wr_ctrl ? wr_data : ctrl_r;
    ctrl_nxt = ctrl_nxt | ctrl_set;
    if (RETURN_FROM_IRQ) begin
      ctrl_nxt[`MIL_B_GEN] = 1'b1;
    end
    if (accept) begin
      ctrl_nxt[`MIL_B_GEN] = 1'b0;
    end
  end

  always_comb begin
    pflag_nxt = (wr_pflags ? wr_data : pflag_r) | pflag_set;
    pflag_nxt = pflag_nxt & `MIL_PERIPH_MASK;
    pen_nxt = (wr_pen ? wr_data : pen_r) & `MIL_PERIPH_MASK;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_r <= `MIL_RST_CONTROL;
      if (!POWER_ON) begin
        ctrl_r[`MIL_B_PCIF] <= ctrl_r[`MIL_B_PCIF];
      end
      pflag_r <= `MIL_RST_PERIPH;
      pen_r <= `MIL_RST_PERIPH;
    end else begin
      ctrl_r <= ctrl_nxt;
      pflag_r <= pflag_nxt;
      pen_r <= pen_nxt;
    end
  end

  assign rd_data = (rd_idx == `MIL_IDX_CONTROL) ? ctrl_r :
                   (rd_idx == `MIL_IDX_PFLAGS) ? pflag_r :
                   (rd_idx == `MIL_IDX_PENABLES) ? pen_r : 8'h00;

  // ----------------------------------------------------------------
  // Request combining
  // ----------------------------------------------------------------
  logic glb_en;
  logic core_req;
  logic periph_req;
  logic any_req;
  assign glb_en = ctrl_r[`MIL_B_GEN];
  assign periph_req = ctrl_r[`MIL_B_PHEN] & (|(pflag_r & pen_r));
  assign core_req = (ctrl_r[`MIL_B_T0EN] & ctrl_r[`MIL_B_T0FL]) |
                    (ctrl_r[`MIL_B_EXTIE] & ctrl_r[`MIL_B_EXTIF]) |
                    (ctrl_r[`MIL_B_PCIE] & ctrl_r[`MIL_B_PCIF]);
  assign any_req = core_req | periph_req;
  // A flag left set by service code re-requests as soon as the enable returns.
  assign IRQ_PENDING = any_req & glb_en;

  // Wake ignores the global enable; the pin needs its own enable beforehand.
  assign WAKE = SLEEPING & any_req;

  // ----------------------------------------------------------------
  // Acceptance sequence
  // ----------------------------------------------------------------
  mil_accept_t st_r;
  mil_accept_t st_nxt;
  logic nop_nxt;
  logic nop_r;
  logic [1:0] nop_cnt_r;

  // A software write that turns the global enable off.
  assign glb_drop = wr_ctrl & ~wr_data[`MIL_B_GEN] & glb_en;

  always_comb begin
    st_nxt = st_r;
    nop_nxt = 1'b0;
    case (st_r)
      MIL_IDLE: begin
        if (q1 && IRQ_PENDING && !glb_drop) begin
          st_nxt = MIL_WAIT1;
        end
      end
      MIL_WAIT1: begin
        if (glb_drop) begin
          st_nxt = MIL_IDLE;
        end else if (q1) begin
          st_nxt = MIL_WAIT2;
        end
      end
      MIL_WAIT2: begin
        if (glb_drop) begin
          st_nxt = MIL_IDLE;
          nop_nxt = 1'b1;
        end else if (q1) begin
          st_nxt = MIL_VECT;
        end
      end
      MIL_VECT: begin
        if (glb_drop) begin
          st_nxt = MIL_IDLE;
          nop_nxt = 1'b1;
        end else if (q1) begin
          st_nxt = MIL_IDLE;
        end
      end
      default: begin
        st_nxt = MIL_IDLE;
      end
    endcase
  end

  // Vector fires on the third Q1 after the sampling Q1; flags are level
  // so an unaligned event simply waits for the next Q1, giving 3 or 4 Tcy.
  assign accept = (st_r == MIL_VECT) && q1 && !glb_drop;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r <= MIL_IDLE;
      nop_r <= 1'b0;
      nop_cnt_r <= 2'd0;
    end else begin
      st_r <= st_nxt;
      if (nop_nxt) begin
        nop_r <= 1'b1;
        nop_cnt_r <= 2'd3;
      end else if (nop_cnt_r != 2'd0) begin
        nop_cnt_r <= nop_cnt_r - 2'd1;
      end else begin
        nop_r <= 1'b0;
      end
    end
  end

  // NOP stands for one whole instruction cycle.
  assign CORE_NOP = nop_r;

  // ----------------------------------------------------------------
  // Vectoring outputs
  // ----------------------------------------------------------------
  // Only the program counter is saved; working state is left to software.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      STACK_PUSH <= 1'b0;
      PC_LOAD <= 1'b0;
      STACK_DATA <= 13'h0000;
      PC_LOAD_VALUE <= 13'h0000;
    end else begin
      STACK_PUSH <= accept;
      PC_LOAD <= accept;
      if (accept) begin
        STACK_DATA <= RETURN_PC;
        PC_LOAD_VALUE <= `MIL_VECTOR;
      end
    end
  end
endmodule

/* testbench/mil_intc_properties.sv */
// Purpose: Concurrent checks on the ports of the interrupt logic.
// Assumes: One clock domain; RESET is synchronous and active high.
// Notes: Bound to every instance of the top module.
`include "mil_params.svh"
module mil_intc_properties (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Core side
  input wire logic [1:0] Q_PHASE,
  input wire logic IRQ_PENDING,
  input wire logic STACK_PUSH,
  input wire logic PC_LOAD,
  input wire mil_pkg::mil_pc_t PC_LOAD_VALUE,
  input wire logic CORE_NOP,
  input wire logic WAKE,
  input wire logic SLEEPING,
  // Bus handshakes
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import mil_pkg::*;
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence nop_tcy_s;
    CORE_NOP [*4] ##1 !CORE_NOP;
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_phase_step: assert property (!$past(RESET) |-> Q_PHASE == $past(Q_PHASE) + 2'h1)
    else $error("quarter phase did not advance by one");
  chk_vector_latency: assert property (PC_LOAD |->
    $past(Q_PHASE, 13) == 2'h0 && $past(IRQ_PENDING, 13))
    else $error("vector without a request sampled three cycles earlier");
  chk_push_with_load: assert property (STACK_PUSH |-> PC_LOAD)
    else $error("stack push apart from vector load");
  chk_vector_addr: assert property (PC_LOAD |=> PC_LOAD_VALUE == `MIL_VECTOR)
    else $error("vector address wrong");
  chk_accept_gie: assert property (PC_LOAD |-> !IRQ_PENDING)
    else $error("global enable still set after acceptance");
  chk_single_accept: assert property (PC_LOAD |=> !PC_LOAD [*8])
    else $error("second acceptance too soon");
  chk_wake_asleep: assert property (WAKE |-> SLEEPING)
    else $error("wake while not sleeping");
  chk_wake_pending: assert property (SLEEPING && IRQ_PENDING |-> WAKE)
    else $error("pending request did not wake");
  chk_nop_tcy: assert property ($rose(CORE_NOP) |-> nop_tcy_s)
    else $error("inserted no-op not one instruction cycle");
  chk_nop_no_vec: assert property (CORE_NOP |-> !PC_LOAD)
    else $error("vector during cancelled cycle");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
  chk_rresp_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read response dropped early");
endmodule
bind mil_intc mil_intc_properties u_props (.CLK(CLK), .RESET(RESET), .Q_PHASE(Q_PHASE),
  .IRQ_PENDING(IRQ_PENDING), .STACK_PUSH(STACK_PUSH), .PC_LOAD(PC_LOAD),
  .PC_LOAD_VALUE(PC_LOAD_VALUE), .CORE_NOP(CORE_NOP), .WAKE(WAKE), .SLEEPING(SLEEPING),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));

/* testbench/mil_core_model.sv */
// Purpose: Behavioural core sequencer facing the interrupt logic.
// Assumes: Service software asks for the return through ret_req.
// Notes: The return delay lets a scenario answer promptly or slowly.
module mil_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // From the interrupt logic
  input wire logic stack_push,
  input wire mil_pkg::mil_pc_t stack_data,
  input wire logic pc_load,
  input wire mil_pkg::mil_pc_t pc_load_value,
  // Service control
  input wire logic ret_req,
  input wire logic [7:0] ret_delay,
  // To the interrupt logic
  output logic return_from_irq = 1'h0,
  output mil_pkg::mil_pc_t return_pc
);
  import mil_pkg::*;
  mil_pc_t stack_q[$];
  mil_pc_t pc_r = 13'h0100;
  int wait_r = -1;
  assign return_pc = pc_r;
  always @(posedge clk) begin
    if (reset) begin
      return_from_irq <= 1'h0;
      pc_r <= 13'h0100;
      wait_r <= -1;
      stack_q.delete();
    end else begin
      pc_r <= pc_r + 13'h0001;
      // Only the return address travels on the stack.
      if (stack_push) stack_q.push_back(stack_data);
      if (pc_load) pc_r <= pc_load_value;
      return_from_irq <= !ret_req && wait_r == 0;
      if (ret_req) begin
        wait_r <= int'(ret_delay);
      end else if (wait_r > 0) begin
        wait_r <= wait_r - 1;
      end else if (wait_r == 0) begin
        wait_r <= -1;
        if (stack_q.size() > 0) pc_r <= stack_q.pop_back();
      end
    end
  end
endmodule

/* testbench/mcu_interrupt_logic_tb_top.sv */
// Purpose: Self-checking bench for the interrupt logic.
// Assumes: Registers sit at four times their index on AXI4-Lite.
// Notes: Expected register values are fixed in each scenario or taken from the value just written.
`include "mil_params.svh"
`define TB_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module mcu_interrupt_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mil_pkg::*;
  localparam logic [9:0] A_CTRL = 10'(4 * `MIL_IDX_CONTROL);
  localparam logic [9:0] A_PF = 10'(4 * `MIL_IDX_PFLAGS);
  localparam logic [9:0] A_PE = 10'(4 * `MIL_IDX_PENABLES);
  logic clk = 1'h0, rst = 1'h1, por = 1'h1;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, push, pcl, nop, wake, pend, rfi;
  logic [1:0] bresp, rresp, qph, rsp_v;
  logic pin = 1'h0, esel = 1'h0, pread = 1'h0, sleeping = 1'h0, ret_req = 1'h0;
  logic [7:0] t0 = 8'h00, pev = 8'h00, ret_dly = 8'h01;
  logic [3:0] pins = 4'h0;
  mil_pc_t sdata, pclv, rpc, rpc_d;
  int errors = 0, cmp_count = 0, cyc = 0, vecs = 0, v0 = 0, ctrl_m = 0;
  int unsigned seed = 63681;
  mil_intc u_dut (.CLK(clk), .RESET(rst), .POWER_ON(por), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .EXT_IRQ_PIN(pin), .EXT_EDGE_SELECT(esel), .TIMER0_COUNT(t0),
    .PORT_PINS(pins), .PORT_READ(pread), .PERIPH_EVENT(pev), .RETURN_FROM_IRQ(rfi),
    .SLEEPING(sleeping), .RETURN_PC(rpc), .Q_PHASE(qph), .STACK_PUSH(push),
    .STACK_DATA(sdata), .PC_LOAD(pcl), .PC_LOAD_VALUE(pclv), .CORE_NOP(nop), .WAKE(wake),
    .IRQ_PENDING(pend));
  mil_core_model u_core (.clk(clk), .reset(rst), .stack_push(push), .stack_data(sdata),
    .pc_load(pcl), .pc_load_value(pclv), .ret_req(ret_req), .ret_delay(ret_dly),
    .return_from_irq(rfi), .return_pc(rpc));
  // ---------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rpc_d <= rpc;
    if (pcl) vecs <= vecs + 1;
    if (pcl) `TB_CHK(sdata, rpc_d)
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset(input logic p);
    @(posedge clk);
    rst <= 1'h1;
    por <= p;
    tick(10);
    rst <= 1'h0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'h0;
      if (wv && wrdy) wv <= 1'h0;
      if (bvalid && !bready) bready <= 1'h1;
    end while (!(bvalid && bready));
    bready <= 1'h0;
    rsp_v = bresp;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'h1;
    do begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'h0;
      if (rvalid && !rready) rready <= 1'h1;
    end while (!(rvalid && rready));
    rready <= 1'h0;
    rd_v = rdata;
    rsp_v = rresp;
  endtask
  task automatic chk_reg(input logic [9:0] a, input int e);
    rd(a);
    `TB_CHK(rd_v, e)
  endtask
  task automatic pulse_ev(input logic [7:0] m);
    @(posedge clk);
    pev <= m;
    @(posedge clk);
    pev <= 8'h00;
  endtask
  task automatic vec_wait();
    for (int k = 0; k < 40 && vecs == v0; k++) @(posedge clk);
    `TB_CHK(vecs, v0 + 1)
  endtask
  task automatic conclude();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    do_reset(1'h1);
    chk_reg(A_CTRL, 0);
    chk_reg(A_PF, 0);
    chk_reg(A_PE, 0);
    rd(10'h3FC);
    `TB_CHK(rsp_v, `MIL_RESP_SLVERR)
    wr(10'h3FC, 8'h00);
    `TB_CHK(rsp_v, `MIL_RESP_SLVERR)
    for (int i = 0; i < 4; i++) begin
      wr(A_PE, rnd() & 8'hFF);
      chk_reg(A_PE, wdata & `MIL_PERIPH_MASK);
      ctrl_m = rnd() & 8'h7F;
      wr(A_CTRL, ctrl_m[7:0]);
      chk_reg(A_CTRL, ctrl_m);
    end
    wr(A_CTRL, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) pulse_ev(8'h01 << i);
    tick(2);
    chk_reg(A_PF, `MIL_PERIPH_MASK);
    wr(A_PF, 8'h00);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      esel <= s[0];
      pin <= ~s[0];
      tick(8);
      wr(A_CTRL, 8'h00);
      @(posedge clk);
      pin <= s[0];
      tick(8);
      chk_reg(A_CTRL, 1 << `MIL_B_EXTIF);
      wr(A_CTRL, 8'h00);
      @(posedge clk);
      pin <= ~s[0];
      tick(8);
      chk_reg(A_CTRL, 0);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      t0 <= 8'hFE + 8'(i);
    end
    tick(3);
    chk_reg(A_CTRL, 1 << `MIL_B_T0FL);
    wr(A_CTRL, 8'h24);
    @(posedge clk);
    sleeping <= 1'h1;
    tick(2);
    `TB_CHK({wake, pend}, 2'h2)
    wr(A_CTRL, 8'h04);
    tick(2);
    `TB_CHK(wake, 1'h0)
    sleeping <= 1'h0;
    wr(A_CTRL, 8'h00);
    $display("test sources done");
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      pins <= pins ^ (4'(rnd()) | 4'h1);
      tick(4);
      chk_reg(A_CTRL, 1);
      pulse_ev(8'h00);
      pread <= 1'h1;
      @(posedge clk);
      pread <= 1'h0;
      if (r == 0) wr(A_CTRL, 8'h00);
      if (r == 0) chk_reg(A_CTRL, 0);
    end
    do_reset(1'h0);
    chk_reg(A_CTRL, 1);
    wr(A_CTRL, 8'h00);
    $display("test port change done");
    for (int d = 1; d < 30; d += 28) begin
      ret_dly <= d[7:0];
      pulse_ev(8'h01);
      wr(A_PE, 8'h01);
      wr(A_CTRL, 8'h80);
      v0 = vecs;
      tick(30);
      `TB_CHK(vecs, v0)
      wr(A_CTRL, 8'hC0);
      vec_wait();
      `TB_CHK(pclv, `MIL_VECTOR)
      chk_reg(A_CTRL, 8'h40);
      wr(A_PF, 8'h00);
      @(posedge clk);
      ret_req <= 1'h1;
      @(posedge clk);
      ret_req <= 1'h0;
      tick(d + 4);
      chk_reg(A_CTRL, 8'hC0);
      `TB_CHK(vecs, v0 + 1)
      wr(A_CTRL, 8'h40);
    end
    $display("test vectoring done");
    pulse_ev(8'h01);
    for (int k = 0; k < 10; k += 2) begin
      v0 = vecs;
      wr(A_CTRL, 8'hC0);
      tick(k);
      wr(A_CTRL, 8'h40);
      tick(30);
      `TB_CHK(vecs, v0)
      chk_reg(A_PF, 1);
    end
    v0 = vecs;
    wr(A_CTRL, 8'hC0);
    vec_wait();
    $display("test cancelled vector done");
    conclude();
  end
endmodule
